// ### core/ide_channel_timing_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ide_timing_map.svh"
// Function
// - ATAPI prefetch bit set lets prefetch run during A0h commands; clear suppresses it.
// - Prefetch decode: lookahead 0 none, 1/0 non-ATAPI only, 1/1 all commands.
// - DMA recovery clocks from speed class and off field: 1-12, then 14/15/16/20.
// - DMA active clocks from speed class and on field, same mapping as recovery.
// - PIO off field codes map to 1,2,3,4,8,9,10,12 clocks.
// - PIO on field codes map to 1,2,3,4,8,9,10,12 clocks.
// - Non-data drive register accesses always use 10 active clocks.
// - Non-data drive register accesses always use 10 recovery clocks.
// - Address setup from top two PIO-on bits: 1, 2, or 3 clocks.
// - Ready sampling on holds PIO strobes while drive ready is low (DMA strobes are never held); off ignores it.
// - Write posting posts data register writes only, never non-data writes.
// - Lookahead bit enables PIO read prefetch; clear means no prefetch at all.
// - Primary half layout: speed 15-14, DMA 13-10, PIO 9-4, flags 3-0.
// - Secondary channel uses the same layout in bits 31-16.
module ide_channel_timing_control (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             cfg_sel_i,
  input  wire logic [7:0]       cfg_addr_i,
  input  wire logic             cfg_we_i,
  input  wire logic [3:0]       cfg_be_i,
  input  wire logic [31:0]      cfg_wdata_i,
  output logic      [31:0]      cfg_rdata_o,
  input  wire logic [1:0]       xfer_req_i,
  input  wire logic [1:0]       xfer_dma_i,
  input  wire logic [1:0]       xfer_write_i,
  input  wire logic [1:0][2:0]  xfer_reg_i,
  input  wire logic [1:0][7:0]  xfer_byte_i,
  output logic      [1:0]       xfer_ready_o,
  output logic      [1:0]       xfer_done_o,
  input  wire logic [1:0]       drive_ready_i,
  output logic      [1:0]       rw_strobe_o,
  output logic      [1:0]       addr_valid_o,
  output logic      [1:0]       prefetch_allow_o,
  output logic      [1:0]       write_post_o,
  output logic      [1:0]       atapi_cmd_o
);
  import ide_timing_pkg::*;

  // ******************************************************************
  // Reset release
  // ******************************************************************
  // Release is synchronised so all flops leave reset on the same edge
  // Entry stays asynchronous so a stopped clock cannot hold off reset
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ******************************************************************
  // Timing configuration word
  // ******************************************************************
  logic [31:0] timing_q;
  logic        cfg_hit;
  assign cfg_hit = cfg_sel_i && (cfg_addr_i == `TIMING_REG_OFFSET);

  // Byte lanes written independently; both halves share one layout
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= `TIMING_RESET;
    end else if (cfg_hit && cfg_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_be_i[b]) begin
          timing_q[b*8 +: 8] <= cfg_wdata_i[b*8 +: 8];
        end
      end
    end
  end

  // Read data registered; unmapped offsets read as zero
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (cfg_sel_i && !cfg_we_i) begin
      cfg_rdata_o <= cfg_hit ? timing_q : 32'h0000_0000;
    end
  end

  // ******************************************************************
  // Drive ready synchronisers
  // ******************************************************************
  // Reset to ready so no false stretch follows reset; only the first flop reads the pin
  logic [1:0] ready_meta_q;
  logic [1:0] ready_sync_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ready_meta_q <= 2'h3;
      ready_sync_q <= 2'h3;
    end else begin
      ready_meta_q <= drive_ready_i;
      ready_sync_q <= ready_meta_q;
    end
  end

  // ******************************************************************
  // Per channel strobe timing and FIFO policy
  // ******************************************************************
  half_cfg_type half [2];
  assign half[0] = timing_q[`HALF_PRI];
  assign half[1] = timing_q[`HALF_SEC];

  logic [1:0] atapi_q;
  logic [1:0] cmd_seen;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic is_data;
      assign is_data = (xfer_reg_i[ch] == `DATA_REG_ADDR);

      ide_strobe_engine u_engine (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n),
        .cfg_i      (half[ch]),
        .req_i      (xfer_req_i[ch]),
        .dma_i      (xfer_dma_i[ch]),
        .data_reg_i (is_data),
        .ready_i    (ready_sync_q[ch]),
        .idle_o     (xfer_ready_o[ch]),
        .strobe_o   (rw_strobe_o[ch]),
        .addr_o     (addr_valid_o[ch]),
        .done_o     (xfer_done_o[ch])
      );

      // A command write decides whether the command now running is a packet command
      assign cmd_seen[ch] = xfer_ready_o[ch] && xfer_req_i[ch] && !xfer_dma_i[ch] &&
                            xfer_write_i[ch] && (xfer_reg_i[ch] == `CMD_REG_ADDR);

      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          atapi_q[ch] <= 1'b0;
        end else if (cmd_seen[ch]) begin
          atapi_q[ch] <= (xfer_byte_i[ch] == `ATAPI_PACKET_CMD);
        end
      end

      // Policy outputs registered so they change one clock after the config or command
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          prefetch_allow_o[ch] <= 1'b0;
          write_post_o[ch]     <= 1'b0;
        end else begin
          prefetch_allow_o[ch] <= half[ch][`B_LOOKAHEAD] &&
                                  (!atapi_q[ch] || half[ch][`B_ATAPI]);
          write_post_o[ch]     <= half[ch][`B_POST] && xfer_req_i[ch] &&
                                  xfer_write_i[ch] && !xfer_dma_i[ch] && is_data;
        end
      end
    end
  endgenerate

  assign atapi_cmd_o = atapi_q;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  chk_reset_fields: assert property ($rose(rst_n) |->
    timing_q[`F_DMA_OFF] == `DMA_FLD_DEF && timing_q[`F_DMA_ON] == `DMA_FLD_DEF &&
    timing_q[`F_SPEED] == `SPEED_SLOW) else $error("timing reset fields wrong");
  chk_no_lookahead: assert property (!timing_q[`B_LOOKAHEAD] |=> !prefetch_allow_o[0])
    else $error("prefetch while lookahead off");
  chk_atapi_block: assert property (atapi_q[1] && !half[1][`B_ATAPI] |=> !prefetch_allow_o[1])
    else $error("prefetch during packet command");
  chk_nondata_post: assert property (xfer_reg_i[0] != `DATA_REG_ADDR |=> !write_post_o[0])
    else $error("non-data write posted");
  chk_reg_write: assert property (cfg_hit && cfg_we_i && cfg_be_i == 4'hf |=>
    timing_q == $past(cfg_wdata_i)) else $error("config write lost");

  // Each policy check above repeated on the other channel; packet flag checked on both
  chk_lookahead_sec: assert property (!half[1][`B_LOOKAHEAD] |=> !prefetch_allow_o[1])
    else $error("secondary prefetch while lookahead off");
  chk_atapi_pri: assert property (atapi_q[0] && !half[0][`B_ATAPI] |=> !prefetch_allow_o[0])
    else $error("primary prefetch during packet command");
  chk_nondata_sec: assert property (xfer_reg_i[1] != `DATA_REG_ADDR |=> !write_post_o[1])
    else $error("secondary non-data write posted");
  chk_packet_flag: assert property (cmd_seen[0] |=>
    atapi_cmd_o[0] == ($past(xfer_byte_i[0]) == `ATAPI_PACKET_CMD)) else $error("packet flag wrong");
  chk_packet_sec: assert property (cmd_seen[1] |=>
    atapi_cmd_o[1] == ($past(xfer_byte_i[1]) == `ATAPI_PACKET_CMD)) else $error("secondary packet flag wrong");

  // Enabled decodes must really turn prefetch and posting on; posting stays off without its enable or a request
  chk_prefetch_all: assert property (half[0][`B_LOOKAHEAD] && half[0][`B_ATAPI] |=>
    prefetch_allow_o[0]) else $error("prefetch for all commands missing");
  chk_prefetch_plain: assert property (half[1][`B_LOOKAHEAD] && !atapi_q[1] |=>
    prefetch_allow_o[1]) else $error("prefetch for plain commands missing");
  chk_post_off: assert property (!half[0][`B_POST] |=> !write_post_o[0])
    else $error("write posted while posting off");
  chk_post_req: assert property (!xfer_req_i[0] |=> !write_post_o[0])
    else $error("write posted without a request");
  chk_post_data: assert property (half[1][`B_POST] && xfer_req_i[1] && xfer_write_i[1] &&
    !xfer_dma_i[1] && xfer_reg_i[1] == `DATA_REG_ADDR |=> write_post_o[1]) else $error("data write not posted");

  // Register reads: the word at its offset, zero elsewhere, no stray writes
  chk_read_back: assert property (cfg_hit && !cfg_we_i |=> cfg_rdata_o == $past(timing_q))
    else $error("config read data wrong");
  chk_unmapped_zero: assert property (cfg_sel_i && !cfg_we_i && !cfg_hit |=> cfg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_unmapped_keep: assert property (cfg_sel_i && cfg_we_i && !cfg_hit |=> $stable(timing_q))
    else $error("unmapped write changed word");

  // Ready reaches the engines two clocks after the pin
  chk_ready_sync: assert property ($past(rst_n, 2) |-> ready_sync_q == $past(drive_ready_i, 2))
    else $error("ready synchroniser latency wrong");
  cov_packet_cmd: cover property (cmd_seen[0] && xfer_byte_i[0] == `ATAPI_PACKET_CMD);
  cov_cfg_read:   cover property (cfg_hit && !cfg_we_i);
endmodule
`default_nettype wire

// ### core/ide_timing_map.svh
`ifndef IDE_TIMING_MAP_SVH
`define IDE_TIMING_MAP_SVH

// ********************************************************************
// Register placement and reset
// ********************************************************************
`define TIMING_REG_OFFSET 8'h44
`define TIMING_RESET      32'hd460d460

// ********************************************************************
// Field layout inside one 16-bit channel half
// ********************************************************************
`define HALF_PRI    15:0
`define HALF_SEC    31:16
`define F_SPEED     15:14
`define F_DMA_OFF   13:12
`define F_DMA_ON    11:10
`define F_PIO_OFF   9:7
`define F_PIO_ON    6:4
`define F_SETUP     6:5
`define B_READY_EN  3
`define B_POST      2
`define B_LOOKAHEAD 1
`define B_ATAPI     0
`define SPEED_SLOW  2'h3
`define DMA_FLD_DEF 2'h1

// ********************************************************************
// Drive register decode
// ********************************************************************
`define DATA_REG_ADDR    3'h0
`define CMD_REG_ADDR     3'h7
`define ATAPI_PACKET_CMD 8'ha0

// ********************************************************************
// Strobe timing in clocks
// ********************************************************************
`define NONDATA_CLKS  5'h0a
`define DMA_CLK_TBL   '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, \
                        5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h14}
`define PIO_CLK_TBL   '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0a, 5'h0c}
`define SETUP_CLK_TBL '{2'h1, 2'h2, 2'h3, 2'h3}

`endif

// ### core/ide_timing_pkg.sv
`default_nettype none
package ide_timing_pkg;
  typedef logic [15:0] half_cfg_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOVER} strobe_state_type;
endpackage
`default_nettype wire

// ### core/ide_strobe_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "ide_timing_map.svh"
module ide_strobe_engine (
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire ide_timing_pkg::half_cfg_type cfg_i,
  input  wire logic                       req_i,
  input  wire logic                       dma_i,
  input  wire logic                       data_reg_i,
  input  wire logic                       ready_i,
  output logic                            idle_o,
  output logic                            strobe_o,
  output logic                            addr_o,
  output logic                            done_o
);
  import ide_timing_pkg::*;

  localparam logic [4:0] DMA_TBL [16] = `DMA_CLK_TBL;
  localparam logic [4:0] PIO_TBL [8]  = `PIO_CLK_TBL;
  localparam logic [1:0] SET_TBL [4]  = `SETUP_CLK_TBL;

  strobe_state_type state_q;
  logic [4:0]       cnt_q;
  logic [4:0]       act_len_q;
  logic [4:0]       rec_len_q;
  logic             dma_q;
  logic             done_q;
  logic [4:0]       act_len_d;
  logic [4:0]       rec_len_d;
  logic [1:0]       setup_len;
  logic             stretch;

  // ******************************************************************
  // Length selection, sampled when a request is taken
  // ******************************************************************
  always_comb begin
    setup_len = SET_TBL[cfg_i[`F_SETUP]];
    if (dma_i) begin
      act_len_d = DMA_TBL[{cfg_i[`F_SPEED], cfg_i[`F_DMA_ON]}];
      rec_len_d = DMA_TBL[{cfg_i[`F_SPEED], cfg_i[`F_DMA_OFF]}];
    end else if (!data_reg_i) begin
      act_len_d = `NONDATA_CLKS;
      rec_len_d = `NONDATA_CLKS;
    end else begin
      act_len_d = PIO_TBL[cfg_i[`F_PIO_ON]];
      rec_len_d = PIO_TBL[cfg_i[`F_PIO_OFF]];
    end
  end

  // Stretch only PIO cycles; DMA pacing does not use the ready line
  assign stretch = cfg_i[`B_READY_EN] && !dma_q && !ready_i;

  // ******************************************************************
  // Strobe sequencer
  // ******************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 5'h00;
      act_len_q <= 5'h01;
      rec_len_q <= 5'h01;
      dma_q     <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (req_i) begin
            act_len_q <= act_len_d;
            rec_len_q <= rec_len_d;
            dma_q     <= dma_i;
            if (dma_i) begin
              state_q <= ST_ACTIVE;
              cnt_q   <= act_len_d - 5'h01;
            end else begin
              state_q <= ST_SETUP;
              cnt_q   <= {3'h0, setup_len} - 5'h01;
            end
          end
        end
        ST_SETUP: begin
          if (cnt_q == 5'h00) begin
            state_q <= ST_ACTIVE;
            cnt_q   <= act_len_q - 5'h01;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        ST_ACTIVE: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (!stretch) begin
            state_q <= ST_RECOVER;
            cnt_q   <= rec_len_q - 5'h01;
          end
        end
        ST_RECOVER: begin
          // Next strobe waits for the whole recovery count
          if (cnt_q == 5'h00) begin
            state_q <= ST_IDLE;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  assign idle_o   = (state_q == ST_IDLE);
  assign strobe_o = (state_q == ST_ACTIVE);
  assign addr_o   = (state_q != ST_IDLE);
  assign done_o   = done_q;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic [5:0] on_cnt_q;
  logic [5:0] off_cnt_q;
  logic       str_seen_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt_q   <= 6'h00;
      off_cnt_q  <= 6'h00;
      str_seen_q <= 1'b0;
    end else begin
      on_cnt_q   <= strobe_o ? on_cnt_q + 6'h01 : 6'h00;
      off_cnt_q  <= (state_q == ST_RECOVER) ? off_cnt_q + 6'h01 : 6'h00;
      str_seen_q <= strobe_o && stretch;
    end
  end

  chk_active_length: assert property ($fell(strobe_o) && !$past(str_seen_q) |->
    $past(on_cnt_q) + 6'h01 >= {1'b0, act_len_q}) else $error("strobe active too short");
  chk_recover_full: assert property (done_o |-> $past(off_cnt_q) + 6'h01 == {1'b0, rec_len_q})
    else $error("recovery count not honoured");
  chk_nondata_ten: assert property (idle_o && req_i && !dma_i && !data_reg_i |=>
    act_len_q == `NONDATA_CLKS && rec_len_q == `NONDATA_CLKS) else $error("non-data timing not 10");
  chk_ready_stretch: assert property (strobe_o && cnt_q == 5'h00 && stretch |=> strobe_o)
    else $error("strobe released while ready low");
  chk_setup_len: assert property (idle_o && req_i && !dma_i && cfg_i[`F_SETUP] == 2'h0 |=>
    ##1 strobe_o) else $error("one clock setup not met");
  chk_pio_table: assert property (idle_o && req_i && !dma_i && data_reg_i && cfg_i[`F_PIO_ON] == 3'h7 |=>
    act_len_q == 5'h0c) else $error("pio active code 7 not 12 clocks");
  chk_dma_slow: assert property (idle_o && req_i && dma_i && cfg_i[`F_SPEED] == `SPEED_SLOW &&
    cfg_i[`F_DMA_OFF] == 2'h3 && cfg_i[`F_DMA_ON] == 2'h3 |=>
    act_len_q == 5'h14 && rec_len_q == 5'h14) else $error("slow dma code 3 not 20 clocks");
  cov_dma_cycle:   cover property (idle_o && req_i && dma_i ##[1:60] done_o);
  cov_pio_stretch: cover property (strobe_o && stretch ##1 strobe_o);
  cov_nondata:     cover property (idle_o && req_i && !data_reg_i ##[1:40] done_o);
endmodule
`default_nettype wire

// ### verification/ide_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Drive on the disk cable: ready pin answers each strobe
// ********************************************************************
module ide_drive_model (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] strobe_i,
  input  wire logic [7:0] stall_i,
  output logic      [1:0] ready_o
);
  logic [1:0]      strobe_q;
  logic [1:0][7:0] wait_q;

  // A rising strobe starts a stall of stall_i clocks; zero answers promptly
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_q <= 2'h0;
      wait_q   <= '0;
    end else begin
      strobe_q <= strobe_i;
      for (int ch = 0; ch < 2; ch++) begin
        if (strobe_i[ch] && !strobe_q[ch]) begin
          wait_q[ch] <= stall_i;
        end else if (wait_q[ch] != 8'h00) begin
          wait_q[ch] <= wait_q[ch] - 8'h01;
        end
      end
    end
  end

  // Ready line has a pull-up, so a released pin reads high
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      ready_o[ch] = (wait_q[ch] == 8'h00);
    end
  end
endmodule
`default_nettype wire

// ### verification/ide_channel_timing_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ide_channel_timing_control_tb;
  logic            clock_i = 1'b0, rst_b_i = 1'b0, cfg_sel_i = 1'b0, cfg_we_i = 1'b0;
  logic [7:0]      cfg_addr_i = 8'h00, stall = 8'h00;
  logic [3:0]      cfg_be_i = 4'h0;
  logic [31:0]     cfg_wdata_i = 32'h0, cfg_rdata_o;
  logic [1:0]      xfer_req_i = 2'h0, xfer_dma_i = 2'h0, xfer_write_i = 2'h0;
  logic [1:0][2:0] xfer_reg_i = '0;
  logic [1:0][7:0] xfer_byte_i = '0;
  logic [1:0]      xfer_ready_o, xfer_done_o, drive_ready_i, rw_strobe_o, addr_valid_o;
  logic [1:0]      prefetch_allow_o, write_post_o, atapi_cmd_o;
  logic            p;
  int              fail_count = 0, checked = 0, s, a, r;

  always #4 clock_i = ~clock_i;

  ide_channel_timing_control u_ide_channel_timing_control (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .cfg_sel_i(cfg_sel_i), .cfg_addr_i(cfg_addr_i), .cfg_we_i(cfg_we_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .xfer_req_i(xfer_req_i), .xfer_dma_i(xfer_dma_i),
    .xfer_write_i(xfer_write_i), .xfer_reg_i(xfer_reg_i), .xfer_byte_i(xfer_byte_i),
    .xfer_ready_o(xfer_ready_o), .xfer_done_o(xfer_done_o), .drive_ready_i(drive_ready_i),
    .rw_strobe_o(rw_strobe_o), .addr_valid_o(addr_valid_o), .prefetch_allow_o(prefetch_allow_o),
    .write_post_o(write_post_o), .atapi_cmd_o(atapi_cmd_o));
  ide_drive_model u_ide_drive_model (.clock_i(clock_i), .rst_b_i(rst_b_i), .strobe_i(rw_strobe_o),
    .stall_i(stall), .ready_o(drive_ready_i));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic int dma_clks(input int i);
    return i < 12 ? i + 1 : (i == 15 ? 20 : i + 2);
  endfunction
  function automatic int pio_clks(input int c);
    return c < 4 ? c + 1 : (c == 7 ? 12 : c + 4);
  endfunction
  // Other channel's half is zeroed: a stray read of it shows up as a wrong length
  function automatic logic [31:0] word(input int ch, input logic [15:0] h);
    return ch ? {h, 16'h0000} : {16'h0000, h};
  endfunction
  task automatic cfg_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
    @(negedge clock_i);
    cfg_sel_i = 1'b1; cfg_we_i = 1'b1; cfg_addr_i = ad; cfg_wdata_i = d; cfg_be_i = be;
    @(negedge clock_i);
    cfg_sel_i = 1'b0; cfg_we_i = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input string name);
    @(negedge clock_i);
    cfg_sel_i = 1'b1; cfg_we_i = 1'b0; cfg_addr_i = ad;
    @(negedge clock_i);
    cfg_sel_i = 1'b0;
    check(name, cfg_rdata_o, exp);
  endtask
  // One transfer; counts setup, strobe and recovery cycles until done
  task automatic xfer(input int ch, input logic dma, input logic wr, input logic [2:0] rg,
                      input logic [7:0] byt, output int su, output int ac, output int rc, output logic post);
    int  n;
    bit  seen;
    su = 0; ac = 0; rc = 0; seen = 0;
    @(negedge clock_i);
    xfer_req_i[ch] = 1'b1; xfer_dma_i[ch] = dma; xfer_write_i[ch] = wr;
    xfer_reg_i[ch] = rg; xfer_byte_i[ch] = byt;
    @(negedge clock_i);
    xfer_req_i[ch] = 1'b0;
    post = write_post_o[ch];
    check("busy_after_take", xfer_ready_o[ch], 1'b0);
    for (n = 0; n < 200; n++) begin
      if (xfer_done_o[ch] === 1'b1) break;
      if (rw_strobe_o[ch] === 1'b1) begin
        ac++; seen = 1;
      end else if (seen) rc++;
      else if (addr_valid_o[ch] === 1'b1) su++;
      @(negedge clock_i);
    end
    if (n == 200) begin
      fail_count++;
      end_of_test();
    end
    check("idle_at_done", xfer_ready_o[ch], 1'b1);
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  initial begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i) rst_b_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rd_chk(8'h44, 32'hd460d460, "reset_word");
    rd_chk(8'h48, 32'h0, "unmapped_read");
    cfg_wr(8'h48, 32'hffffffff, 4'hf);
    rd_chk(8'h44, 32'hd460d460, "unmapped_write");
    cfg_wr(8'h44, 32'h12345678, 4'h5);
    rd_chk(8'h44, 32'hd434d478, "byte_lanes");
    // Every class is swept, fast ones too, as software may pick any
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 16; i++) begin
        cfg_wr(8'h44, word(ch, {i[3:2], ~i[1:0], i[1:0], 10'h000}), 4'hf);
        xfer(ch, 1'b1, 1'b0, 3'h0, 8'h00, s, a, r, p);
        check("dma_on", a, dma_clks(i));
        check("dma_off", r, dma_clks({i[3:2], ~i[1:0]}));
        check("dma_setup", s, 0);
      end
      // Slowest code in both fields
      cfg_wr(8'h44, word(ch, 16'hfc00), 4'hf);
      xfer(ch, 1'b1, 1'b0, 3'h0, 8'h00, s, a, r, p);
      check("dma_slowest_on", a, 20);
      check("dma_slowest_off", r, 20);
      for (int c = 0; c < 8; c++) begin
        cfg_wr(8'h44, word(ch, {6'h35, 3'(7 - c), 3'(c), 4'h0}), 4'hf);
        xfer(ch, 1'b0, 1'b0, 3'h0, 8'h00, s, a, r, p);
        check("pio_on", a, pio_clks(c));
        check("pio_off", r, pio_clks(7 - c));
        check("pio_setup", s, c >= 4 ? 3 : (c >= 2 ? 2 : 1));
      end
      // Non-data register ignores both PIO fields
      cfg_wr(8'h44, word(ch, 16'hd400), 4'hf);
      xfer(ch, 1'b0, 1'b0, 3'h1, 8'h00, s, a, r, p);
      check("nondata_on", a, 10);
      check("nondata_off", r, 10);
      check("nondata_setup", s, 1);
    end
    // Slow drive: stretch only when ready sampling is on
    stall = 8'h08;
    cfg_wr(8'h44, word(0, 16'hd430), 4'hf);
    xfer(0, 1'b0, 1'b0, 3'h0, 8'h00, s, a, r, p);
    check("ready_ignored", a, 4);
    cfg_wr(8'h44, word(0, 16'hd438), 4'hf);
    xfer(0, 1'b0, 1'b0, 3'h0, 8'h00, s, a, r, p);
    check("ready_stretch", 32'((a > 4) && (a < 16)), 1);
    stall = 8'h00;
    // Posting: data writes only, and only when enabled
    cfg_wr(8'h44, word(1, 16'hd404), 4'hf);
    xfer(1, 1'b0, 1'b1, 3'h0, 8'h11, s, a, r, p);
    check("post_data", p, 1);
    xfer(1, 1'b0, 1'b1, 3'h7, 8'h20, s, a, r, p);
    check("post_nondata", p, 0);
    cfg_wr(8'h44, word(1, 16'hd400), 4'hf);
    xfer(1, 1'b0, 1'b1, 3'h0, 8'h11, s, a, r, p);
    check("post_off", p, 0);
    // Prefetch decode over command kind and both policy bits
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 2; k++) begin
        xfer(ch, 1'b0, 1'b1, 3'h7, k ? 8'ha0 : 8'h20, s, a, r, p);
        check("atapi_cmd", atapi_cmd_o[ch], k);
        for (int j = 0; j < 4; j++) begin
          cfg_wr(8'h44, word(ch, {14'h3500, j[1:0]}), 4'hf);
          repeat (2) @(negedge clock_i);
          check("prefetch", prefetch_allow_o[ch], j[1] & (!k | j[0]));
        end
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
